/* rtl/dee_access_ctrl.sv */
// Register-side controller for the 128-byte data EEPROM.
// Assumes one special function register access per clock, each clock being one
// instruction cycle, and reset event inputs synchronous to the clock.
`default_nettype none

module dee_access_ctrl
   import dee_pkg::*;
#(
   parameter int P_PWRT_CYCLES = PWRT_CYCLES,
   parameter int P_WR_CYCLES   = WRITE_CYCLES
) (
   input  wire logic       i_sys_clk,
   input  wire logic       i_rstn,
   input  wire logic [7:0] i_sfr_addr,
   input  wire logic       i_sfr_we,
   input  wire logic [7:0] i_sfr_wdata,
   input  wire logic       i_sfr_re,
   output logic      [7:0] o_sfr_rdata,
   input  wire logic       i_external_reset_pin_n,
   input  wire logic       i_watchdog_timeout,
   input  wire logic       i_brownout_detect,
   input  wire logic       i_data_protect_fuse_n,
   input  wire logic [6:0] i_prog_addr,
   input  wire logic       i_prog_rd,
   input  wire logic       i_prog_wr,
   input  wire logic [7:0] i_prog_wdata,
   output logic      [7:0] o_prog_rdata,
   output logic            o_write_done_flag,
   output logic            o_write_busy
);

   localparam int PW = $clog2(P_PWRT_CYCLES + 1);
   localparam logic [PW-1:0] PWRT_LOAD = PW'(P_PWRT_CYCLES);

   typedef struct packed {
      logic [7:0]        data;
      logic [ADDR_W-1:0] loc;
      logic              wallow;
      logic              wr;
      logic              rd;
      logic              abort_flag;
      logic              done_flag;
      dee_ulk_t          ulk;
      logic [1:0]        ulk_cnt;
      logic [PW-1:0]     pwrt_cnt;
      logic [7:0]        rdata;
   } dee_ctl_st_t;

   localparam dee_ctl_st_t ST_RESET = '{
      data: RESET_BYTE, loc: '0, wallow: 1'b0, wr: 1'b0, rd: 1'b0,
      abort_flag: 1'b0, done_flag: 1'b0, ulk: ULK_IDLE, ulk_cnt: 2'h0,
      pwrt_cnt: PWRT_LOAD, rdata: RESET_BYTE
   };

   logic [1:0]  rst_sync;
   logic        rst_n;
   dee_ctl_st_t st;
   dee_ctl_st_t next_st;
   logic        wr_go;
   logic        armed;
   logic        reset_evt;
   logic        busy;

   dee_arr_if #(.AW(ADDR_W)) arr ();

   // ==========================================================
   // Reset release
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // ==========================================================
   // Cell array
   dee_cell_array #(
      .WR_CYCLES (P_WR_CYCLES)
   ) u_cells (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (rst_n),
      .arr       (arr.cells)
   );

   assign busy           = arr.busy;
   assign reset_evt      = !i_external_reset_pin_n | i_watchdog_timeout | i_brownout_detect;
   assign arr.start      = wr_go;
   assign arr.abort      = reset_evt;
   assign arr.wr_addr    = st.loc;
   assign arr.wr_data    = st.data;
   assign arr.rd_addr    = st.loc;
   // Programmer port is gated off entirely while data protection is set
   assign arr.prog_rd    = i_prog_rd & i_data_protect_fuse_n;
   assign arr.prog_wr    = i_prog_wr & i_data_protect_fuse_n;
   assign arr.prog_addr  = i_prog_addr;
   assign arr.prog_wdata = i_prog_wdata;

   // ==========================================================
   // Register file, unlock sequencer and strobes
   always_comb begin
      next_st = st;
      wr_go   = 1'b0;
      armed   = 1'b0;

      if (st.pwrt_cnt != '0) begin
         next_st.pwrt_cnt = st.pwrt_cnt - 1'b1;
      end
      if (st.ulk_cnt != 2'h3) begin
         next_st.ulk_cnt = st.ulk_cnt + 1'b1;
      end

      // Any stray register write inside the sequence breaks it
      unique case (st.ulk)
         ULK_IDLE: begin
            if (i_sfr_we && i_sfr_addr == ADR_UNLOCK && i_sfr_wdata == UNLOCK_KEY1) begin
               next_st.ulk     = ULK_KEY1;
               next_st.ulk_cnt = 2'h1;
            end
         end
         ULK_KEY1: begin
            if (st.ulk_cnt == GAP_KEY2 && i_sfr_we && i_sfr_addr == ADR_UNLOCK
                && i_sfr_wdata == UNLOCK_KEY2) begin
               next_st.ulk     = ULK_KEY2;
               next_st.ulk_cnt = 2'h1;
            end else if (i_sfr_we || st.ulk_cnt >= GAP_KEY2) begin
               next_st.ulk = ULK_IDLE;
            end
         end
         ULK_KEY2: begin
            armed = (st.ulk_cnt == GAP_START);
            if (i_sfr_we || st.ulk_cnt >= GAP_START) begin
               next_st.ulk = ULK_IDLE;
            end
         end
         default: begin
            next_st.ulk = ULK_IDLE;
         end
      endcase
      if (busy || st.wr) begin
         next_st.ulk = ULK_IDLE;
         armed       = 1'b0;
      end

      if (i_sfr_we) begin
         unique case (i_sfr_addr)
            ADR_DATA: begin
               if (!busy) begin
                  next_st.data = i_sfr_wdata;
               end
            end
            ADR_LOCATION: begin
               if (!busy) begin
                  next_st.loc = i_sfr_wdata[ADDR_W-1:0];
               end
            end
            ADR_CONTROL: begin
               next_st.wallow     = i_sfr_wdata[BIT_WALLOW];
               next_st.abort_flag = i_sfr_wdata[BIT_ABORT];
               if (i_sfr_wdata[BIT_RD] && !busy) begin
                  next_st.rd = 1'b1;
               end
               // Write-allow is taken as it stood before this write
               if (i_sfr_wdata[BIT_WR] && armed && st.wallow && !busy
                   && st.pwrt_cnt == '0) begin
                  next_st.wr = 1'b1;
                  wr_go      = 1'b1;
               end
            end
            ADR_IRQ_FLAGS: begin
               next_st.done_flag = i_sfr_wdata[BIT_DONE];
            end
            default: begin
               next_st = next_st;
            end
         endcase
      end

      if (st.rd) begin
         next_st.data = arr.rd_data;
         next_st.rd   = 1'b0;
      end
      if (arr.done) begin
         next_st.wr        = 1'b0;
         next_st.done_flag = 1'b1;
      end

      if (i_sfr_re) begin
         unique case (i_sfr_addr)
            ADR_IRQ_FLAGS: next_st.rdata = {st.done_flag, 7'h00};
            ADR_DATA:      next_st.rdata = st.data;
            ADR_LOCATION:  next_st.rdata = {1'b0, st.loc};
            ADR_CONTROL:   next_st.rdata = {4'h0, st.abort_flag, st.wallow, st.wr, st.rd};
            default:       next_st.rdata = 8'h00;
         endcase
      end

      // Reset events clear the block like a reset; the abort flag, power-up count and read data survive
      if (reset_evt) begin
         next_st            = ST_RESET;
         next_st.pwrt_cnt   = st.pwrt_cnt;
         next_st.rdata      = st.rdata;
         next_st.abort_flag = st.abort_flag | busy;
         wr_go              = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs
   assign o_sfr_rdata       = st.rdata;
   assign o_prog_rdata      = i_data_protect_fuse_n ? arr.prog_rdata : 8'h00;
   assign o_write_done_flag = st.done_flag;
   assign o_write_busy      = st.wr;

endmodule : dee_access_ctrl

`default_nettype wire

/* rtl/dee_pkg.sv */
// Shared constants and types of the data EEPROM access controller.
// Assumes a 100 MHz system clock and an 8-bit special function register port.
`default_nettype none

package dee_pkg;

   // ==========================================================
   // Array geometry
   localparam int         ARR_DEPTH     = 128;
   localparam int         ADDR_W        = 7;
   localparam logic [7:0] ERASED_BYTE   = 8'hFF;
   localparam logic [7:0] RESET_BYTE    = 8'h00;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] ADR_IRQ_FLAGS = 8'h0C;
   localparam logic [7:0] ADR_DATA      = 8'h9A;
   localparam logic [7:0] ADR_LOCATION  = 8'h9B;
   localparam logic [7:0] ADR_CONTROL   = 8'h9C;
   localparam logic [7:0] ADR_UNLOCK    = 8'h9D;

   // ==========================================================
   // Field positions
   localparam int         BIT_RD        = 0;
   localparam int         BIT_WR        = 1;
   localparam int         BIT_WALLOW    = 2;
   localparam int         BIT_ABORT     = 3;
   localparam int         BIT_DONE      = 7;

   // ==========================================================
   // Unlock sequence: keys and exact spacing in clock cycles
   localparam logic [7:0] UNLOCK_KEY1   = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2   = 8'hAA;
   localparam logic [1:0] GAP_KEY2      = 2'h2;
   localparam logic [1:0] GAP_START     = 2'h1;

   // ==========================================================
   // Timing
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         PWRT_TIME_MS  = 72;
   localparam int         PWRT_CYCLES   = PWRT_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int         WRITE_TIME_US = 4000;
   localparam int         WRITE_CYCLES  = WRITE_TIME_US * 1000 / CLK_PERIOD_NS;

   // ==========================================================
   // State encodings
   typedef enum logic [1:0] {
      ULK_IDLE = 2'b00,
      ULK_KEY1 = 2'b01,
      ULK_KEY2 = 2'b10
   } dee_ulk_t;

   typedef enum logic [1:0] {
      PH_IDLE  = 2'b00,
      PH_ERASE = 2'b01,
      PH_PROG  = 2'b10
   } dee_phase_t;

endpackage : dee_pkg

`default_nettype wire

/* rtl/dee_arr_if.sv */
// Connection between the register controller and the cell array.
// Assumes both ends run on the same clock.
`default_nettype none

interface dee_arr_if #(parameter int AW = 7);
   logic          start;
   logic          abort;
   logic [AW-1:0] wr_addr;
   logic [7:0]    wr_data;
   logic          busy;
   logic          done;
   logic [AW-1:0] rd_addr;
   logic [7:0]    rd_data;
   logic          prog_rd;
   logic          prog_wr;
   logic [AW-1:0] prog_addr;
   logic [7:0]    prog_wdata;
   logic [7:0]    prog_rdata;

   modport ctrl (
      output start, abort, wr_addr, wr_data, rd_addr,
      output prog_rd, prog_wr, prog_addr, prog_wdata,
      input  busy, done, rd_data, prog_rdata
   );

   modport cells (
      input  start, abort, wr_addr, wr_data, rd_addr,
      input  prog_rd, prog_wr, prog_addr, prog_wdata,
      output busy, done, rd_data, prog_rdata
   );
endinterface : dee_arr_if

`default_nettype wire

/* rtl/dee_cell_array.sv */
// Byte-wide nonvolatile cell array with timed erase-then-program writes.
// Assumes a synchronised active-low reset and one start pulse per write.
`default_nettype none

module dee_cell_array
   import dee_pkg::*;
#(
   parameter int WR_CYCLES = WRITE_CYCLES
) (
   input  wire logic i_sys_clk,
   input  wire logic i_rstn,
   dee_arr_if.cells  arr
);

   localparam int CW = $clog2(WR_CYCLES + 1);
   localparam int HALF = (WR_CYCLES / 2 > 0) ? WR_CYCLES / 2 : 1;
   localparam logic [CW-1:0] ERASE_CNT = CW'(HALF - 1);
   localparam logic [CW-1:0] PROG_CNT  = CW'((WR_CYCLES > HALF) ? WR_CYCLES - HALF - 1 : 0);

   typedef struct packed {
      dee_phase_t        phase;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
      logic [CW-1:0]     cnt;
      logic              done;
      logic [7:0]        prog_q;
   } dee_cell_st_t;

   // Cells keep their contents across resets, so the array has no reset
   logic [7:0]   mem [ARR_DEPTH];
   dee_cell_st_t st;
   dee_cell_st_t next_st;

   // ==========================================================
   // Erase and program sequencer
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      if (arr.prog_rd) begin
         next_st.prog_q = mem[arr.prog_addr];
      end
      unique case (st.phase)
         PH_IDLE: begin
            if (arr.start) begin
               next_st.phase = PH_ERASE;
               next_st.addr  = arr.wr_addr;
               next_st.data  = arr.wr_data;
               next_st.cnt   = ERASE_CNT;
            end
         end
         PH_ERASE: begin
            if (st.cnt == '0) begin
               next_st.phase = PH_PROG;
               next_st.cnt   = PROG_CNT;
            end else begin
               next_st.cnt = st.cnt - 1'b1;
            end
         end
         PH_PROG: begin
            if (st.cnt == '0) begin
               next_st.phase = PH_IDLE;
               next_st.done  = 1'b1;
            end else begin
               next_st.cnt = st.cnt - 1'b1;
            end
         end
         default: begin
            next_st.phase = PH_IDLE;
         end
      endcase
      if (arr.abort) begin
         next_st.phase = PH_IDLE;
         next_st.done  = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st <= '{phase: PH_IDLE, addr: '0, data: RESET_BYTE, cnt: '0, done: 1'b0,
                 prog_q: RESET_BYTE};
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Cell writes
   always_ff @(posedge i_sys_clk) begin
      if (st.phase == PH_ERASE && !arr.abort) begin
         mem[st.addr] <= ERASED_BYTE;
      end else if (st.phase == PH_PROG && st.cnt == '0 && !arr.abort) begin
         mem[st.addr] <= st.data;
      end else if (st.phase == PH_IDLE && !arr.start && arr.prog_wr) begin
         mem[arr.prog_addr] <= arr.prog_wdata;
      end
   end

   assign arr.busy       = (st.phase != PH_IDLE);
   assign arr.done       = st.done;
   assign arr.rd_data    = mem[arr.rd_addr];
   assign arr.prog_rdata = st.prog_q;

endmodule : dee_cell_array

`default_nettype wire

/* verification/dee_access_ctrl_checker.sv */
// Port checker of the data EEPROM access controller.
// Assumes it is bound into dee_access_ctrl; one clock domain.
`default_nettype none

module dee_access_ctrl_checker
   import dee_pkg::*;
#(
   parameter int P_WR_CYCLES = WRITE_CYCLES
) (
   input wire logic       i_sys_clk,
   input wire logic       i_rstn,
   input wire logic [7:0] i_sfr_addr,
   input wire logic       i_sfr_we,
   input wire logic [7:0] i_sfr_wdata,
   input wire logic       i_sfr_re,
   input wire logic [7:0] o_sfr_rdata,
   input wire logic       i_external_reset_pin_n,
   input wire logic       i_watchdog_timeout,
   input wire logic       i_brownout_detect,
   input wire logic       i_data_protect_fuse_n,
   input wire logic [7:0] o_prog_rdata,
   input wire logic       o_write_done_flag,
   input wire logic       o_write_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ev;
   int   cnt;

   // ======
   // Busy length counter
   assign ev = !i_external_reset_pin_n || i_watchdog_timeout || i_brownout_detect;
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt <= 0;
      end else begin
         cnt <= o_write_busy ? cnt + 1 : 0;
      end
   end

   // ======
   // Assertions
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rstn);

   a_rdata_hold: assert property (!$past(i_sfr_re) |-> $stable(o_sfr_rdata))
      else $error("read data moved without a read");
   a_unlock_zero: assert property (i_sfr_re && i_sfr_addr == ADR_UNLOCK
      |=> o_sfr_rdata == 8'h00) else $error("unlock register not zero");
   a_ctrl_upper: assert property (i_sfr_re && i_sfr_addr == ADR_CONTROL
      |=> o_sfr_rdata[7:4] == 4'h0 && o_sfr_rdata[BIT_WR] == $past(o_write_busy))
      else $error("control read wrong");
   a_loc_top: assert property (i_sfr_re && i_sfr_addr == ADR_LOCATION
      |=> !o_sfr_rdata[7]) else $error("location top bit set");
   a_flags_read: assert property (i_sfr_re && i_sfr_addr == ADR_IRQ_FLAGS
      |=> o_sfr_rdata == {$past(o_write_done_flag), 7'h00}) else $error("flags read wrong");
   a_start_cause: assert property ($rose(o_write_busy) |->
      $past(i_sfr_we && i_sfr_addr == ADR_CONTROL && i_sfr_wdata[BIT_WR]))
      else $error("write began without strobe");
   a_write_timed: assert property ($fell(o_write_busy) && !$past(ev) |->
      o_write_done_flag && $past(cnt) >= P_WR_CYCLES - 2) else $error("write ended early");
   a_busy_bound: assert property (o_write_busy |-> cnt < P_WR_CYCLES + 8)
      else $error("write ran too long");
   a_done_sticky: assert property ($fell(o_write_done_flag) |-> $past(ev ||
      (i_sfr_we && i_sfr_addr == ADR_IRQ_FLAGS && !i_sfr_wdata[BIT_DONE])))
      else $error("done flag dropped");
   a_event_clears: assert property (ev |=> !o_write_busy && !o_write_done_flag)
      else $error("reset event did not stop");
   a_prog_block: assert property (!i_data_protect_fuse_n |-> o_prog_rdata == 8'h00)
      else $error("programmer read not blocked");
endmodule : dee_access_ctrl_checker

bind dee_access_ctrl dee_access_ctrl_checker #(.P_WR_CYCLES(P_WR_CYCLES)) dee_chk (
   .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_sfr_addr(i_sfr_addr), .i_sfr_we(i_sfr_we),
   .i_sfr_wdata(i_sfr_wdata), .i_sfr_re(i_sfr_re), .o_sfr_rdata(o_sfr_rdata),
   .i_external_reset_pin_n(i_external_reset_pin_n), .i_watchdog_timeout(i_watchdog_timeout),
   .i_brownout_detect(i_brownout_detect), .i_data_protect_fuse_n(i_data_protect_fuse_n),
   .o_prog_rdata(o_prog_rdata), .o_write_done_flag(o_write_done_flag),
   .o_write_busy(o_write_busy));

`default_nettype wire

/* verification/dee_prog_model.sv */
// Behavioural device programmer on the far side of the programming port.
// Assumes one-cycle requests from the bench, given at the rising edge.
`default_nettype none

module dee_prog_model (
   input  wire logic       i_clk,
   input  wire logic       i_rd,
   input  wire logic       i_wr,
   input  wire logic [6:0] i_addr,
   input  wire logic [7:0] i_data,
   output logic      [6:0] o_prog_addr,
   output logic            o_prog_rd,
   output logic            o_prog_wr,
   output logic      [7:0] o_prog_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_prog_addr = 7'h00;
      o_prog_rd = 1'b0;
      o_prog_wr = 1'b0;
      o_prog_wdata = 8'h00;
   end
   // Idle address and data lines toggle so a stale address never looks valid
   always @(posedge i_clk) begin
      o_prog_rd <= i_rd;
      o_prog_wr <= i_wr;
      if (i_rd || i_wr) begin
         o_prog_addr <= i_addr;
         o_prog_wdata <= i_data;
      end else begin
         o_prog_addr <= ~o_prog_addr;
         o_prog_wdata <= ~o_prog_wdata;
      end
   end
endmodule : dee_prog_model

`default_nettype wire

/* verification/dee_access_ctrl_test.sv */
// Self-checking bench of the data EEPROM access controller.
// Assumes dee_pkg; power-up and write counts are shortened for speed.
`default_nettype none

module dee_access_ctrl_test
   import dee_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PWRT = 20;
   localparam int WRC = 8;
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [7:0] wd = 8'h00;
   logic       we = 1'b0;
   logic       re = 1'b0;
   logic [2:0] evs = 3'h0;
   logic       fuse_n = 1'b1;
   logic       p_rd = 1'b0;
   logic       p_wr = 1'b0;
   logic [6:0] p_adr = 7'h00;
   logic [15:0] r = 16'hC9F2;
   logic [7:0] rdat, prdat, pwd, a, d, la;
   logic [6:0] pa;
   logic       prd, pwr, done, busy;
   logic [7:0] mem [128];
   int         n_mismatch = 0;
   int         checks = 0;

   dee_access_ctrl #(.P_PWRT_CYCLES(PWRT), .P_WR_CYCLES(WRC)) dee_access_ctrl_inst (
      .i_sys_clk(clk), .i_rstn(rstn), .i_sfr_addr(adr), .i_sfr_we(we), .i_sfr_wdata(wd),
      .i_sfr_re(re), .o_sfr_rdata(rdat), .i_external_reset_pin_n(~evs[0]),
      .i_watchdog_timeout(evs[1]), .i_brownout_detect(evs[2]),
      .i_data_protect_fuse_n(fuse_n), .i_prog_addr(pa), .i_prog_rd(prd), .i_prog_wr(pwr),
      .i_prog_wdata(pwd), .o_prog_rdata(prdat), .o_write_done_flag(done),
      .o_write_busy(busy));
   dee_prog_model dee_prog_model_inst (.i_clk(clk), .i_rd(p_rd), .i_wr(p_wr),
      .i_addr(p_adr), .i_data(~la), .o_prog_addr(pa), .o_prog_rd(prd),
      .o_prog_wr(pwr), .o_prog_wdata(pwd));

   always #5 clk = ~clk;

   // ======
   // Helpers
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      adr <= ad;
      wd <= dt;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
      adr <= ad;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      @(posedge clk);
      chk(rdat, exp);
   endtask : rd
   // Key gap of one is the legal spacing; larger gaps must be refused
   task automatic arm(input int gap, input logic [7:0] c);
      wr(ADR_UNLOCK, UNLOCK_KEY1);
      repeat (gap - 1) @(posedge clk);
      wd <= UNLOCK_KEY2;
      we <= 1'b1;
      @(posedge clk);
      adr <= ADR_CONTROL;
      wd <= c;
      @(posedge clk);
      we <= 1'b0;
      @(posedge clk);
   endtask : arm
   task automatic wait_idle();
      for (int i = 0; i < 200 && busy !== 1'b0; i++) begin
         @(posedge clk);
      end
      chk({7'h0, busy}, 8'h00);
   endtask : wait_idle
   task automatic end_of_test();
      $display("Mismatches %0d, checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test

   // ======
   // Scenarios
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      end_of_test();
   end
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      rd(ADR_CONTROL, 8'h00);
      wr(ADR_CONTROL, 8'h04);
      arm(1, 8'h06);
      chk({7'h0, busy}, 8'h00);
      rd(ADR_DATA, 8'h00);
      rd(ADR_LOCATION, 8'h00);
      rd(ADR_UNLOCK, 8'h00);
      rd(ADR_IRQ_FLAGS, 8'h00);
      rd(8'h55, 8'h00);
      repeat (PWRT) @(posedge clk);
      wr(ADR_CONTROL, 8'h00);
      arm(1, 8'h02);
      chk({7'h0, busy}, 8'h00);
      wr(ADR_CONTROL, 8'h04);
      arm(2, 8'h06);
      chk({7'h0, busy}, 8'h00);
      rd(ADR_CONTROL, 8'h04);
      for (int k = 0; k < 4; k++) begin
         r = lfsr(r);
         a = r[7:0];
         d = r[15:8];
         wr(ADR_LOCATION, a);
         wr(ADR_DATA, d);
         wr(ADR_CONTROL, 8'h04);
         arm(1, 8'h06);
         chk({7'h0, busy}, 8'h01);
         wr(ADR_DATA, ~d);
         wr(ADR_CONTROL, 8'h00);
         rd(ADR_CONTROL, 8'h02);
         wait_idle();
         chk({7'h0, done}, 8'h01);
         mem[a[6:0]] = d;
         la = {1'b0, a[6:0]};
         rd(ADR_DATA, d);
         rd(ADR_IRQ_FLAGS, 8'h80);
         wr(ADR_IRQ_FLAGS, 8'h00);
         rd(ADR_IRQ_FLAGS, 8'h00);
         wr(ADR_DATA, ~d);
         wr(ADR_LOCATION, a ^ 8'h80);
         wr(ADR_CONTROL, 8'h01);
         rd(ADR_DATA, d);
         rd(ADR_LOCATION, {1'b0, a[6:0]});
         rd(ADR_CONTROL, 8'h00);
      end
      for (int e = 0; e < 3; e++) begin
         wr(ADR_LOCATION, 8'h11);
         wr(ADR_DATA, 8'h3C);
         wr(ADR_CONTROL, 8'h04);
         arm(1, 8'h06);
         evs[e] <= 1'b1;
         @(posedge clk);
         evs <= 3'h0;
         @(posedge clk);
         rd(ADR_CONTROL, 8'h08);
         rd(ADR_DATA, 8'h00);
         rd(ADR_LOCATION, 8'h00);
         wr(ADR_CONTROL, 8'h00);
         rd(ADR_CONTROL, 8'h00);
      end
      p_adr <= la[6:0];
      p_rd <= 1'b1;
      @(posedge clk);
      p_rd <= 1'b0;
      repeat (3) @(posedge clk);
      chk(prdat, mem[la[6:0]]);
      fuse_n <= 1'b0;
      p_wr <= 1'b1;
      @(posedge clk);
      p_wr <= 1'b0;
      repeat (3) @(posedge clk);
      chk(prdat, 8'h00);
      wr(ADR_LOCATION, la);
      wr(ADR_CONTROL, 8'h01);
      rd(ADR_DATA, mem[la[6:0]]);
      end_of_test();
   end
endmodule : dee_access_ctrl_test

`default_nettype wire
